/* File: pod_pkg.sv */
// Package with register map, field positions and state types of the output-disable block
// Behaviour
// - One enable raises the interrupt on any of the four lower request inputs.
// - One enable raises the interrupt on a short in a channel 3/4 output pair.
// - The eighth request input has its own interrupt enable, apart from the lower one.
// - Lower requests and output shorts share one interrupt, each gated by its enable.
// - Eighth-input requests use a second, separate interrupt output.
// - Software forces and releases channel 3 and 4 outputs to high impedance together.
// - Software forces and releases channel 0 outputs to high impedance independently.
// - Software clears each event flag on its own by writing a one.
// - Clearing a level-triggered flag fails while its input is still asserted.
// - Each lower request input has a readable flag, one meaning requested.
// - Oscillation-stop, eighth-input and output-short flags are readable too.
package pod_pkg;

  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_REQ   = 5;
  localparam int NUM_SRC   = 6;
  localparam int NUM_PAIR  = 3;
  localparam int IDX_IN8   = 4;
  localparam int IDX_OSC   = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h0C;

  // Status, enable and control field positions
  localparam int ST_LOWER_LSB = 0;
  localparam int ST_IN8       = 8;
  localparam int ST_OSC       = 9;
  localparam int ST_SHORT     = 14;
  localparam int IE_LOWER     = 0;
  localparam int IE_IN8       = 8;
  localparam int IE_SHORT     = 14;
  localparam int CT_FORCE34   = 0;
  localparam int CT_FORCE0    = 1;

  localparam logic [DATA_W-1:0] STATUS_MASK = 16'h430F;
  localparam logic [DATA_W-1:0] IRQ_EN_MASK = 16'h4101;
  localparam logic [DATA_W-1:0] LOWER_MASK  = 16'h000F;

  // Reset values
  localparam logic [DATA_W-1:0]  STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0]  IRQ_EN_RST = 16'h0000;
  localparam logic [1:0]         CTRL_RST   = 2'h0;
  localparam logic [NUM_REQ-1:0] MODE_RST   = 5'h00;
  localparam logic [NUM_SRC-1:0] SRC_RST    = 6'h00;

  typedef struct packed {
    logic [NUM_SRC-1:0] sync1;
    logic [NUM_SRC-1:0] sync2;
    logic [NUM_SRC-1:0] prev;
  } pod_cond_s;

  typedef struct packed {
    logic [DATA_W-1:0]  status;
    logic [DATA_W-1:0]  irq_en;
    logic               force34;
    logic               force0;
    logic [NUM_REQ-1:0] level_mode;
    logic [DATA_W-1:0]  rdata;
    logic               irq_ls;
    logic               irq_8;
    logic               hiz34;
    logic               hiz0;
  } pod_top_s;

endpackage

/* File: pod_req_if.sv */
// Interface carrying conditioned request events from the input stage to the core
`timescale 1ns/1ns
interface pod_req_if;
  import pod_pkg::*;
  logic [NUM_SRC-1:0] onset;
  logic [NUM_SRC-1:0] active;
  modport src (output onset, output active);
  modport dst (input onset, input active);
endinterface

/* File: pod_req_cond.sv */
// Input stage: synchronises request pins and the stop detector, finds onsets
`timescale 1ns/1ns
module pod_req_cond
  import pod_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // Raw sources: request pins active low, stop detector active high
  input  wire logic [NUM_REQ-1:0] req_n_i,
  input  wire logic               osc_stop_i,
  // Conditioned events
  pod_req_if.src                  req
);

  pod_cond_s state_r;
  pod_cond_s state_nxt;
  logic [NUM_SRC-1:0] act;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      if (gi == IDX_OSC) begin : g_hi
        assign act[gi] = state_r.sync2[gi];
      end else begin : g_lo
        assign act[gi] = ~state_r.sync2[gi];
      end
      assign req.onset[gi]  = act[gi] & ~state_r.prev[gi];
      assign req.active[gi] = act[gi];
    end
  endgenerate

  always_comb begin
    state_nxt       = state_r;
    state_nxt.sync1 = {osc_stop_i, req_n_i};
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev  = act;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r.sync1 <= {1'b0, {NUM_REQ{1'b1}}};
      state_r.sync2 <= {1'b0, {NUM_REQ{1'b1}}};
      state_r.prev  <= SRC_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule

/* File: pod_top.sv */
// Output-disable core: event flags, interrupts, forced high impedance, register port
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
module pod_top
  import pod_pkg::*;
(
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  // Request pins, in0..in3 then in8, active low
  input  wire logic [NUM_REQ-1:0]  disable_request_in_n_i,
  input  wire logic                osc_stop_i,
  // Channel 3/4 complementary outputs, pair k on bits 2k and 2k+1
  input  wire logic [2*NUM_PAIR-1:0] timer_pair_out_i,
  // Interrupts
  output logic                     irq_lower_short_o,
  output logic                     irq_eighth_o,
  // High impedance controls
  output logic                     hiz_ch34_o,
  output logic                     hiz_ch0_o
);

  pod_top_s state_r;
  pod_top_s state_nxt;

  pod_req_if req ();

  pod_req_cond u_cond (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .req_n_i    (disable_request_in_n_i),
    .osc_stop_i (osc_stop_i),
    .req        (req.src)
  );

  logic [NUM_REQ-1:0]  req_evt;
  logic [NUM_REQ-1:0]  req_hold;
  logic [NUM_PAIR-1:0] pair_short;
  logic                short_evt;
  logic [DATA_W-1:0]   set_vec;
  logic [DATA_W-1:0]   hold_vec;
  logic [DATA_W-1:0]   clr_vec;
  logic                wr_status;
  logic                wr_irq_en;
  logic                wr_ctrl;
  logic                wr_mode;

  // Per-input trigger selection: edge onset or asserted level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
      assign req_evt[gi]  = state_r.level_mode[gi] ? req.active[gi] : req.onset[gi];
      assign req_hold[gi] = state_r.level_mode[gi] & req.active[gi];
    end
    for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair
      assign pair_short[gi] = timer_pair_out_i[2*gi] & timer_pair_out_i[2*gi+1];
    end
  endgenerate

  assign short_evt = |pair_short;

  assign wr_status = wr_i && (addr_i == OFF_STATUS);
  assign wr_irq_en = wr_i && (addr_i == OFF_IRQ_EN);
  assign wr_ctrl   = wr_i && (addr_i == OFF_CTRL);
  assign wr_mode   = wr_i && (addr_i == OFF_MODE);

  always_comb begin
    set_vec                                = '0;
    set_vec[ST_LOWER_LSB +: 4]             = req_evt[3:0];
    set_vec[ST_IN8]                        = req_evt[IDX_IN8];
    set_vec[ST_OSC]                        = req.onset[IDX_OSC];
    set_vec[ST_SHORT]                      = short_evt;
    hold_vec                               = '0;
    hold_vec[ST_LOWER_LSB +: 4]            = req_hold[3:0];
    hold_vec[ST_IN8]                       = req_hold[IDX_IN8];
    clr_vec = wr_status ? (wdata_i & STATUS_MASK & ~hold_vec) : '0;
  end

  always_comb begin
    state_nxt = state_r;
    // Set wins over a clear in the same cycle
    state_nxt.status = ((state_r.status & ~clr_vec) | set_vec) & STATUS_MASK;
    if (wr_irq_en) begin
      state_nxt.irq_en = wdata_i & IRQ_EN_MASK;
    end
    if (wr_ctrl) begin
      state_nxt.force34 = wdata_i[CT_FORCE34];
      state_nxt.force0  = wdata_i[CT_FORCE0];
    end
    if (wr_mode) begin
      state_nxt.level_mode = wdata_i[NUM_REQ-1:0];
    end
    state_nxt.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OFF_STATUS: state_nxt.rdata = state_r.status;
        OFF_IRQ_EN: state_nxt.rdata = state_r.irq_en;
        OFF_CTRL:   state_nxt.rdata = {14'h0000, state_r.force0, state_r.force34};
        OFF_MODE:   state_nxt.rdata = {11'h000, state_r.level_mode};
        default:    state_nxt.rdata = '0;
      endcase
    end
    state_nxt.irq_ls =
      (state_nxt.irq_en[IE_LOWER] && |(state_nxt.status & LOWER_MASK)) ||
      (state_nxt.irq_en[IE_SHORT] && state_nxt.status[ST_SHORT]);
    state_nxt.irq_8  = state_nxt.irq_en[IE_IN8] && state_nxt.status[ST_IN8];
    state_nxt.hiz34  = state_nxt.force34 ||
                       |(state_nxt.status & LOWER_MASK) ||
                       state_nxt.status[ST_SHORT] || state_nxt.status[ST_OSC];
    state_nxt.hiz0   = state_nxt.force0 ||
                       state_nxt.status[ST_IN8] || state_nxt.status[ST_OSC];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r.status     <= STATUS_RST;
      state_r.irq_en     <= IRQ_EN_RST;
      state_r.force34    <= CTRL_RST[CT_FORCE34];
      state_r.force0     <= CTRL_RST[CT_FORCE0];
      state_r.level_mode <= MODE_RST;
      state_r.rdata      <= '0;
      state_r.irq_ls     <= 1'b0;
      state_r.irq_8      <= 1'b0;
      state_r.hiz34      <= 1'b0;
      state_r.hiz0       <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata_o           = state_r.rdata;
  assign irq_lower_short_o = state_r.irq_ls;
  assign irq_eighth_o      = state_r.irq_8;
  assign hiz_ch34_o        = state_r.hiz34;
  assign hiz_ch0_o         = state_r.hiz0;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  AST_IRQ_LOWER: assert property (
    (state_r.irq_en[IE_LOWER] && |(state_r.status & LOWER_MASK)) |-> irq_lower_short_o
  ) else $error("lower request flag enabled but shared interrupt low");

  AST_IRQ_SHORT: assert property (
    (state_r.irq_en[IE_SHORT] && state_r.status[ST_SHORT]) |-> irq_lower_short_o
  ) else $error("short flag enabled but shared interrupt low");

  AST_IRQ_EIGHTH: assert property (
    irq_eighth_o == (state_r.irq_en[IE_IN8] && state_r.status[ST_IN8])
  ) else $error("eighth interrupt does not follow its flag and enable");

  AST_IRQ_SHARED_CAUSE: assert property (
    irq_lower_short_o |->
      ((state_r.irq_en[IE_LOWER] && |(state_r.status & LOWER_MASK)) ||
       (state_r.irq_en[IE_SHORT] && state_r.status[ST_SHORT]))
  ) else $error("shared interrupt high without enabled cause");

  AST_IRQ_SEPARATE: assert property (
    (state_r.status[ST_IN8] && state_r.irq_en[IE_IN8] &&
     !state_r.irq_en[IE_LOWER] && !state_r.irq_en[IE_SHORT])
      |-> (irq_eighth_o && !irq_lower_short_o)
  ) else $error("eighth request leaked onto shared interrupt");

  AST_FORCE34: assert property (
    (wr_ctrl && wdata_i[CT_FORCE34]) |=> hiz_ch34_o
  ) else $error("channel 3/4 not forced to high impedance");

  AST_FORCE0: assert property (
    (wr_ctrl && wdata_i[CT_FORCE0]) |=> hiz_ch0_o
  ) else $error("channel 0 not forced to high impedance");

  AST_RELEASE0: assert property (
    (wr_ctrl && !wdata_i[CT_FORCE0] && !state_r.status[ST_IN8] &&
     !state_r.status[ST_OSC] && !set_vec[ST_IN8] && !set_vec[ST_OSC])
      |=> !hiz_ch0_o
  ) else $error("channel 0 not released");

  AST_CLEAR_SHORT: assert property (
    (wr_status && wdata_i[ST_SHORT] && !short_evt) |=> !state_r.status[ST_SHORT]
  ) else $error("short flag not cleared by write of one");

  AST_LEVEL_HOLD: assert property (
    (wr_status && wdata_i[0] && state_r.level_mode[0] && req.active[0])
      |=> state_r.status[0]
  ) else $error("level flag cleared while input asserted");

  AST_LOWER_FLAG: assert property (
    req_evt[1] |=> state_r.status[1]
  ) else $error("lower request flag not set");

  AST_OSC_FLAG: assert property (
    req.onset[IDX_OSC] |=> state_r.status[ST_OSC] && hiz_ch0_o && hiz_ch34_o
  ) else $error("oscillation stop flag or hold-off missing");

  AST_STICKY: assert property (
    $fell(state_r.status[0]) |-> $past(wr_status) && $past(wdata_i[0])
  ) else $error("lower flag dropped without software clear");

  AST_RDATA: assert property (
    (rd_i && addr_i == OFF_STATUS) |=> rdata_o == $past(state_r.status)
  ) else $error("status read data wrong");

  AST_IRQ_LOWER_OFF: assert property (
    (!state_r.irq_en[IE_LOWER] && !state_r.irq_en[IE_SHORT]) |-> !irq_lower_short_o
  ) else $error("shared interrupt high with both enables clear");

  AST_IRQ_EIGHTH_OFF: assert property (
    !state_r.irq_en[IE_IN8] |-> !irq_eighth_o
  ) else $error("eighth interrupt high with its enable clear");

  AST_IRQ_NO_IN8_LEAK: assert property (
    (!(|(state_r.status & LOWER_MASK)) && !state_r.status[ST_SHORT]) |-> !irq_lower_short_o
  ) else $error("shared interrupt high without lower or short flag");

  AST_FORCE34_HOLD: assert property (
    state_r.force34 |-> hiz_ch34_o
  ) else $error("channel 3/4 force set but outputs driven");

  AST_RELEASE34: assert property (
    (wr_ctrl && !wdata_i[CT_FORCE34] && !(|(state_r.status & LOWER_MASK)) &&
     !state_r.status[ST_SHORT] && !state_r.status[ST_OSC] &&
     (set_vec[3:0] == 4'h0) && !set_vec[ST_SHORT] && !set_vec[ST_OSC])
      |=> !hiz_ch34_o
  ) else $error("channel 3/4 not released");

  AST_FORCE34_ALONE: assert property (
    (wr_ctrl && !wdata_i[CT_FORCE34]) |=> !state_r.force34
  ) else $error("channel 3/4 force not released by software");

  AST_FORCE0_HOLD: assert property (
    state_r.force0 |-> hiz_ch0_o
  ) else $error("channel 0 force set but outputs driven");

  AST_FORCE0_ALONE: assert property (
    (wr_ctrl && !wdata_i[CT_FORCE0]) |=> !state_r.force0
  ) else $error("channel 0 force not released by software");

  AST_CTRL_KEEP: assert property (
    !wr_ctrl |=> $stable(state_r.force34) && $stable(state_r.force0)
  ) else $error("force bits changed without a control write");

  AST_HIZ34_CAUSE: assert property (
    hiz_ch34_o |-> (state_r.force34 || |(state_r.status & LOWER_MASK) ||
                    state_r.status[ST_SHORT] || state_r.status[ST_OSC])
  ) else $error("channel 3/4 high impedance without a cause");

  AST_HIZ0_CAUSE: assert property (
    hiz_ch0_o |-> (state_r.force0 || state_r.status[ST_IN8] || state_r.status[ST_OSC])
  ) else $error("channel 0 high impedance without a cause");

  AST_CLEAR_LOWER: assert property (
    (wr_status && wdata_i[2] && !state_r.level_mode[2] && !req_evt[2]) |=> !state_r.status[2]
  ) else $error("lower flag not cleared by write of one");

  AST_CLEAR_IN8: assert property (
    (wr_status && wdata_i[ST_IN8] && !state_r.level_mode[IDX_IN8] && !req_evt[IDX_IN8])
      |=> !state_r.status[ST_IN8]
  ) else $error("eighth flag not cleared by write of one");

  AST_CLEAR_OSC: assert property (
    (wr_status && wdata_i[ST_OSC] && !req.onset[IDX_OSC]) |=> !state_r.status[ST_OSC]
  ) else $error("stop flag not cleared by write of one");

  AST_CLEAR_OTHERS_KEEP: assert property (
    (wr_status && !wdata_i[2] && state_r.status[2]) |=> state_r.status[2]
  ) else $error("flag cleared by a write of zero");

  AST_LEVEL_HOLD_IN8: assert property (
    (wr_status && wdata_i[ST_IN8] && state_r.level_mode[IDX_IN8] && req.active[IDX_IN8])
      |=> state_r.status[ST_IN8]
  ) else $error("eighth level flag cleared while input asserted");

  AST_LEVEL_REASSERT: assert property (
    (state_r.level_mode[3] && req.active[3]) |=> state_r.status[3]
  ) else $error("level flag not held while input asserted");

  AST_LOWER_SET: assert property (
    (req_evt[3:0] != 4'h0) |=>
      (state_r.status[3:0] & $past(req_evt[3:0])) == $past(req_evt[3:0])
  ) else $error("lower request flags not set");

  AST_IN8_FLAG: assert property (
    req_evt[IDX_IN8] |=> state_r.status[ST_IN8] && hiz_ch0_o
  ) else $error("eighth request flag or hold-off missing");

  AST_SHORT_FLAG: assert property (
    short_evt |=> state_r.status[ST_SHORT] && hiz_ch34_o
  ) else $error("short flag or hold-off missing");

  AST_STICKY_IN8: assert property (
    $fell(state_r.status[ST_IN8]) |-> $past(wr_status) && $past(wdata_i[ST_IN8])
  ) else $error("eighth flag dropped without software clear");

  AST_STICKY_OSC: assert property (
    $fell(state_r.status[ST_OSC]) |-> $past(wr_status) && $past(wdata_i[ST_OSC])
  ) else $error("stop flag dropped without software clear");

  AST_STICKY_SHORT: assert property (
    $fell(state_r.status[ST_SHORT]) |-> $past(wr_status) && $past(wdata_i[ST_SHORT])
  ) else $error("short flag dropped without software clear");

  AST_RDATA_IDLE: assert property (
    !rd_i |=> rdata_o == 16'h0000
  ) else $error("read data not zero outside a read");

  AST_RDATA_CTRL: assert property (
    (rd_i && addr_i == OFF_CTRL) |=>
      rdata_o == {14'h0000, $past(state_r.force0), $past(state_r.force34)}
  ) else $error("control read data wrong");

endmodule

/* File: pod_far_model.sv */
// Far-side model: request pins, stop detector and channel 3/4 output pairs
`timescale 1ns/1ns
module pod_far_model
  import pod_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // Event commands from the bench
  input  wire logic [NUM_REQ-1:0]    req_on_i,
  input  wire logic                  osc_on_i,
  input  wire logic [NUM_PAIR-1:0]   short_on_i,
  // Pins towards the block
  output logic      [NUM_REQ-1:0]    req_n_o,
  output logic                       osc_stop_o,
  output logic      [2*NUM_PAIR-1:0] pair_o
);
  logic phase_r;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Pairs swap each cycle; a commanded short drives both high
  always_comb begin
    req_n_o    = ~req_on_i;
    osc_stop_o = osc_on_i;
    for (int k = 0; k < NUM_PAIR; k++) begin
      pair_o[2*k]   = phase_r | short_on_i[k];
      pair_o[2*k+1] = ~phase_r | short_on_i[k];
    end
  end
endmodule

/* File: testbench.sv */
// Self-checking testbench for the output-disable block
`timescale 1ns/1ns
module testbench;
  import pod_pkg::*;
  logic                    clock_i  = 1'b0;
  logic                    rst_i    = 1'b1;
  logic [ADDR_W-1:0]       addr_i   = 8'h00;
  logic [DATA_W-1:0]       wdata_i  = 16'h0000;
  logic                    wr_i     = 1'b0;
  logic                    rd_i     = 1'b0;
  logic [8:0]              ev       = 9'h000;
  logic [DATA_W-1:0]       rdata_o;
  logic [NUM_REQ-1:0]      req_n;
  logic                    osc_stop;
  logic [2*NUM_PAIR-1:0]   pair_out;
  logic                    irq_ls;
  logic                    irq_8;
  logic                    hiz34;
  logic                    hiz0;
  int                      failures = 0;
  int                      n_checks = 0;
  int                      cycles   = 0;
  wire  [DATA_W-1:0]       outs     = {12'h000, irq_ls, irq_8, hiz34, hiz0};

  always #5 clock_i = ~clock_i;

  pod_far_model far (
    .clock_i    (clock_i),
    .rst_i      (rst_i),
    .req_on_i   (ev[4:0]),
    .osc_on_i   (ev[5]),
    .short_on_i (ev[8:6]),
    .req_n_o    (req_n),
    .osc_stop_o (osc_stop),
    .pair_o     (pair_out)
  );

  pod_top dut (
    .clock_i                (clock_i),
    .rst_i                  (rst_i),
    .addr_i                 (addr_i),
    .wdata_i                (wdata_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rdata_o                (rdata_o),
    .disable_request_in_n_i (req_n),
    .osc_stop_i             (osc_stop),
    .timer_pair_out_i       (pair_out),
    .irq_lower_short_o      (irq_ls),
    .irq_eighth_o           (irq_8),
    .hiz_ch34_o             (hiz34),
    .hiz_ch0_o              (hiz0)
  );

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  // Holds one event source active for two cycles, then lets the flag settle
  task automatic pulse(input int i);
    @(posedge clock_i);
    ev[i] <= 1'b1;
    repeat (2) @(posedge clock_i);
    ev[i] <= 1'b0;
    idle(5);
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles >= 5000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    idle(1);
    chk(outs, 16'h0000);
    rd(OFF_STATUS, STATUS_RST);
    rd(OFF_IRQ_EN, IRQ_EN_RST);
    rd(OFF_MODE, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(OFF_CTRL, 16'h0001);
    idle(1);
    chk(outs, 16'h0002);
    rd(OFF_CTRL, 16'h0001);
    wr(OFF_CTRL, 16'h0002);
    idle(1);
    chk(outs, 16'h0001);
    wr(OFF_CTRL, 16'h0000);
    idle(1);
    chk(outs, 16'h0000);
    wr(OFF_IRQ_EN, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      chk(outs, 16'h000A);
      rd(OFF_STATUS, 16'h0001 << i);
      wr(OFF_STATUS, 16'h0001 << i);
      idle(1);
      chk(outs, 16'h0000);
    end
    wr(OFF_IRQ_EN, 16'h0000);
    pulse(1);
    pulse(2);
    chk(outs, 16'h0002);
    wr(OFF_STATUS, 16'h0002);
    rd(OFF_STATUS, 16'h0004);
    wr(OFF_STATUS, 16'h0004);
    wr(OFF_IRQ_EN, 16'h0100);
    pulse(0);
    chk(outs, 16'h0002);
    wr(OFF_STATUS, 16'h0001);
    pulse(4);
    chk(outs, 16'h0005);
    rd(OFF_STATUS, 16'h0100);
    wr(OFF_STATUS, 16'h0100);
    idle(1);
    chk(outs, 16'h0000);
    wr(OFF_IRQ_EN, 16'h4000);
    for (int k = 0; k < 3; k++) begin
      pulse(6 + k);
      chk(outs, 16'h000A);
      rd(OFF_STATUS, 16'h4000);
      wr(OFF_STATUS, 16'h4000);
      idle(1);
      chk(outs, 16'h0000);
    end
    wr(OFF_IRQ_EN, 16'h4101);
    rd(OFF_IRQ_EN, 16'h4101);
    pulse(5);
    chk(outs, 16'h0003);
    rd(OFF_STATUS, 16'h0200);
    wr(OFF_STATUS, 16'h0200);
    rd(OFF_STATUS, 16'h0000);
    wr(OFF_MODE, 16'h0019);
    rd(OFF_MODE, 16'h0019);
    @(posedge clock_i);
    ev[4:0] <= 5'h19;
    idle(6);
    wr(OFF_STATUS, 16'h0109);
    idle(2);
    chk(outs, 16'h000F);
    rd(OFF_STATUS, 16'h0109);
    @(posedge clock_i);
    ev[4:0] <= 5'h00;
    idle(5);
    wr(OFF_STATUS, 16'h0109);
    rd(OFF_STATUS, 16'h0000);
    idle(1);
    chk(outs, 16'h0000);
    wr(OFF_MODE, 16'h0000);
    rd(OFF_MODE, 16'h0000);
    end_sim();
  end
endmodule
